// File: core/i2cte_cfg.svh
// Notes on behaviour
// R1: First byte bits 7..1 compared to own address; bit 0 gives direction.
// R2: Only 7-bit addressing; ten-bit address format is not recognised.
// R3: Own address resets to zero; software should change it from general call.
// R4: Leading write bytes fill command buffer; event when full or write ends.
// R5: Command length zero disables command capture; length resets to zero.
// R6: Data buffer gets bytes after command prefix, or all bytes without capture.
// R7: Write-data event when data buffer full or write ends; length resets 128.
// R8: Hold time zero, the reset value, keeps target on bus after writes.
// R9: Positive hold time detaches target that many milliseconds after write data.
// R10: Halt hold value detaches and halts until a new start command.
// R11: Stretched operation gets at least the time limit before abandonment; resets 30000.
// R12: Pull-up enable switches internal pull-ups on data and clock lines.
// R13: Command or data event stays pending until software drains every byte.
// R14: After a master read, read-done event reports bytes sent.
// R15: Detached or halted target ignores its address; attached acks only own.
// R16: Read addressing raises read-request event; clock stretched until byte supplied.
`ifndef I2CTE_CFG_SVH
`define I2CTE_CFG_SVH
`define I2CTE_A_CTRL     8'h00
`define I2CTE_A_ADDR     8'h04
`define I2CTE_A_CMDLEN   8'h08
`define I2CTE_A_DATLEN   8'h0C
`define I2CTE_A_HOLD     8'h10
`define I2CTE_A_TMO      8'h14
`define I2CTE_A_STAT     8'h18
`define I2CTE_A_MASK     8'h1C
`define I2CTE_A_RXD      8'h20
`define I2CTE_A_TXD      8'h24
`define I2CTE_A_INFO     8'h28
`define I2CTE_CTRL_START 0
`define I2CTE_CTRL_STOP  1
`define I2CTE_CTRL_PULL  2
`define I2CTE_EV_CMD     0
`define I2CTE_EV_DAT     1
`define I2CTE_EV_RRQ     2
`define I2CTE_EV_RDN     3
`define I2CTE_EV_TMO     4
`define I2CTE_RST_ADDR   7'h00
`define I2CTE_RST_CMDLEN 8'h00
`define I2CTE_RST_DATLEN 8'h80
`define I2CTE_RST_HOLD   16'h0000
`define I2CTE_HOLD_HALT  16'hFFFF
`define I2CTE_RST_TMO    16'h7530
`define I2CTE_NBITS      4'h8
`define I2CTE_MS_NS      1000000
`define I2CTE_CLK_NS     4
`define I2CTE_RESP_OK    2'h0
`define I2CTE_RESP_ERR   2'h2
`endif

// File: core/i2cte_pkg.sv
package i2cte_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_AACK = 3'h3,
		ST_WDAT = 3'h2,
		ST_WACK = 3'h6,
		ST_RLD  = 3'h7,
		ST_RDAT = 3'h5,
		ST_RACK = 3'h4
	} i2cte_state_t;
endpackage : i2cte_pkg

// File: core/i2cte_top.sv
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "i2cte_cfg.svh"
module i2cte_top #(
	parameter int CYC_PER_MS = `I2CTE_MS_NS / `I2CTE_CLK_NS
) (
	input  wire logic        CLOCK_I,
	input  wire logic        RST_I,
	input  wire logic [7:0]  AWADDR_I,
	input  wire logic        AWVALID_I,
	output wire logic        AWREADY_O,
	input  wire logic [31:0] WDATA_I,
	input  wire logic [3:0]  WSTRB_I,
	input  wire logic        WVALID_I,
	output wire logic        WREADY_O,
	output wire logic [1:0]  BRESP_O,
	output wire logic        BVALID_O,
	input  wire logic        BREADY_I,
	input  wire logic [7:0]  ARADDR_I,
	input  wire logic        ARVALID_I,
	output wire logic        ARREADY_O,
	output wire logic [31:0] RDATA_O,
	output wire logic [1:0]  RRESP_O,
	output wire logic        RVALID_O,
	input  wire logic        RREADY_I,
	input  wire logic        SCL_I,
	output wire logic        SCL_O,
	output wire logic        SCL_OE_N_O,
	input  wire logic        SDA_I,
	output wire logic        SDA_O,
	output wire logic        SDA_OE_N_O,
	output wire logic        PULLUP_EN_O,
	output wire logic        IRQ_O
);
	function automatic logic reg_hit(input logic [7:0] a);
		return a inside {`I2CTE_A_CTRL, `I2CTE_A_ADDR, `I2CTE_A_CMDLEN, `I2CTE_A_DATLEN,
			`I2CTE_A_HOLD, `I2CTE_A_TMO, `I2CTE_A_STAT, `I2CTE_A_MASK, `I2CTE_A_RXD,
			`I2CTE_A_TXD, `I2CTE_A_INFO};
	endfunction : reg_hit

	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i])
				r[i*8 +: 8] = n[i*8 +: 8];
		end
		return r;
	endfunction : wmerge

	i2cte_pkg::i2cte_state_t st_q;
	logic [2:0]  scl_sy_q, sda_sy_q;
	logic        scl_q, sda_q, scl_p_q, sda_p_q;
	logic [7:0]  sh_q;
	logic [3:0]  bit_q;
	logic        sda_drv_q, scl_hold_q, rw_q, writing_q, reading_q;
	logic [7:0]  tx_q, tx_cnt_q, rd_done_cnt_q;
	logic        tx_full_q;
	logic [7:0]  buf_q [0:127];
	logic [7:0]  wr_cnt_q, ev_cnt_q, rd_ptr_q;
	logic        cmd_pend_q, dat_pend_q, phase_cmd_q;
	logic [6:0]  own_addr_q;
	logic [7:0]  cmd_len_q, dat_len_q;
	logic [15:0] hold_q, tmo_q, away_ms_q;
	logic [16:0] tmo_ms_q;
	logic        pull_q, attached_q, halted_q, away_q;
	logic [4:0]  stat_q, mask_q;
	logic [31:0] cyc_q;
	logic [7:0]  aw_q;
	logic [31:0] w_q;
	logic [3:0]  ws_q;
	logic        aw_v_q, w_v_q, bvalid_q, rvalid_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [31:0] rdata_q, rd_val, wm;

	logic scl_rise, scl_fall, start, stop, abort, xfer_end, ms_tick, on_bus, pend_any;
	logic push, take, addr_ok, stall, fill, endw, raise, rrq, rdn;
	logic do_wr, ar_hs, rd_stat, rd_rx;
	logic [7:0] cnt_nx;

	// a change counts only once the second and third stages agree
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			scl_sy_q <= 3'h7;
			sda_sy_q <= 3'h7;
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
			scl_p_q  <= 1'b1;
			sda_p_q  <= 1'b1;
		end else begin
			scl_sy_q <= {scl_sy_q[1:0], SCL_I};
			sda_sy_q <= {sda_sy_q[1:0], SDA_I};
			if (scl_sy_q[1] == scl_sy_q[2])
				scl_q <= scl_sy_q[2];
			if (sda_sy_q[1] == sda_sy_q[2])
				sda_q <= sda_sy_q[2];
			scl_p_q <= scl_q;
			sda_p_q <= sda_q;
		end
	end

	assign scl_rise = scl_q & ~scl_p_q;
	assign scl_fall = ~scl_q & scl_p_q;
	assign start    = scl_q & scl_p_q & ~sda_q & sda_p_q;
	assign stop     = scl_q & scl_p_q & sda_q & ~sda_p_q;
	assign xfer_end = start | stop | abort;
	assign on_bus   = attached_q & ~away_q;
	assign pend_any = cmd_pend_q | dat_pend_q;

	// 7-bit compare only; ten-bit headers simply miss [R1] [R2] [R15]
	assign addr_ok = st_q == i2cte_pkg::ST_ADDR && bit_q == `I2CTE_NBITS && !scl_q && on_bus
		&& sh_q[7:1] == own_addr_q;
	assign push  = st_q == i2cte_pkg::ST_WDAT && bit_q == `I2CTE_NBITS && !scl_q && !pend_any;
	assign take  = st_q == i2cte_pkg::ST_RLD && tx_full_q && !scl_q;
	// kept one cycle past the data change, so the line settles before the clock rises
	assign stall = !scl_q && ((st_q == i2cte_pkg::ST_WDAT && bit_q == `I2CTE_NBITS)
		|| st_q == i2cte_pkg::ST_RLD); // [R16]
	assign rrq   = st_q == i2cte_pkg::ST_AACK && scl_fall && rw_q && !xfer_end; // [R16]
	assign rdn   = xfer_end && reading_q; // [R14]

	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			st_q      <= i2cte_pkg::ST_IDLE;
			sh_q      <= 8'h00;
			bit_q     <= 4'h0;
			sda_drv_q <= 1'b0;
			rw_q      <= 1'b0;
			writing_q <= 1'b0;
			reading_q <= 1'b0;
			tx_cnt_q  <= 8'h00;
		end else if (xfer_end) begin
			st_q      <= start ? i2cte_pkg::ST_ADDR : i2cte_pkg::ST_IDLE;
			bit_q     <= 4'h0;
			sda_drv_q <= 1'b0;
			writing_q <= 1'b0;
			reading_q <= 1'b0;
		end else begin
			unique case (st_q)
				i2cte_pkg::ST_IDLE: begin
				end
				i2cte_pkg::ST_ADDR: begin
					if (scl_rise && bit_q != `I2CTE_NBITS) begin
						sh_q  <= {sh_q[6:0], sda_q};
						bit_q <= bit_q + 4'h1;
					end else if (bit_q == `I2CTE_NBITS && !scl_q) begin
						if (addr_ok) begin
							st_q      <= i2cte_pkg::ST_AACK;
							sda_drv_q <= 1'b1;
							rw_q      <= sh_q[0];
							writing_q <= ~sh_q[0];
							reading_q <= sh_q[0];
							tx_cnt_q  <= 8'h00;
						end else begin
							st_q <= i2cte_pkg::ST_IDLE;
						end
					end
				end
				i2cte_pkg::ST_WDAT: begin
					if (scl_rise && bit_q != `I2CTE_NBITS) begin
						sh_q  <= {sh_q[6:0], sda_q};
						bit_q <= bit_q + 4'h1;
					end else if (push) begin
						st_q      <= i2cte_pkg::ST_WACK;
						sda_drv_q <= 1'b1;
					end
				end
				i2cte_pkg::ST_AACK, i2cte_pkg::ST_WACK: begin
					if (scl_fall) begin
						sda_drv_q <= 1'b0;
						bit_q     <= 4'h0;
						st_q      <= (st_q == i2cte_pkg::ST_AACK && rw_q) ?
							i2cte_pkg::ST_RLD : i2cte_pkg::ST_WDAT;
					end
				end
				i2cte_pkg::ST_RLD: begin
					if (take) begin
						sda_drv_q <= ~tx_q[7];
						sh_q      <= {tx_q[6:0], 1'b0};
						bit_q     <= 4'h1;
						tx_cnt_q  <= tx_cnt_q + 8'h01; // [R14]
						st_q      <= i2cte_pkg::ST_RDAT;
					end
				end
				i2cte_pkg::ST_RDAT: begin
					if (scl_fall) begin
						if (bit_q == `I2CTE_NBITS) begin
							sda_drv_q <= 1'b0;
							st_q      <= i2cte_pkg::ST_RACK;
						end else begin
							sda_drv_q <= ~sh_q[7];
							sh_q      <= {sh_q[6:0], 1'b0};
							bit_q     <= bit_q + 4'h1;
						end
					end
				end
				i2cte_pkg::ST_RACK: begin
					if (scl_rise && sda_q)
						st_q <= i2cte_pkg::ST_IDLE;
					else if (scl_fall)
						st_q <= i2cte_pkg::ST_RLD;
				end
			endcase
		end
	end

	// one buffer serves both phases; a pending event stalls the next byte
	assign cnt_nx = wr_cnt_q + 8'h01;
	assign fill   = push && cnt_nx == (phase_cmd_q ? cmd_len_q : dat_len_q); // [R4] [R7]
	assign endw   = !push && xfer_end && writing_q && wr_cnt_q != 8'h00; // [R4] [R7]
	assign raise  = fill | endw;

	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			wr_cnt_q    <= 8'h00;
			ev_cnt_q    <= 8'h00;
			rd_ptr_q    <= 8'h00;
			cmd_pend_q  <= 1'b0;
			dat_pend_q  <= 1'b0;
			phase_cmd_q <= 1'b0;
		end else begin
			if (rd_rx && pend_any) begin
				rd_ptr_q <= rd_ptr_q + 8'h01;
				if (rd_ptr_q + 8'h01 == ev_cnt_q) begin
					cmd_pend_q <= 1'b0; // [R13]
					dat_pend_q <= 1'b0;
				end
			end
			if (addr_ok && !sh_q[0]) begin
				phase_cmd_q <= cmd_len_q != `I2CTE_RST_CMDLEN; // [R5] [R6]
				wr_cnt_q    <= 8'h00;
			end else if (raise) begin
				cmd_pend_q  <= phase_cmd_q;
				dat_pend_q  <= ~phase_cmd_q;
				ev_cnt_q    <= fill ? cnt_nx : wr_cnt_q;
				rd_ptr_q    <= 8'h00;
				wr_cnt_q    <= 8'h00;
				phase_cmd_q <= 1'b0; // [R6]
			end else if (push) begin
				wr_cnt_q <= cnt_nx;
			end
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (push)
			buf_q[wr_cnt_q[6:0]] <= sh_q;
	end

	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			cyc_q   <= 32'h0;
			ms_tick <= 1'b0;
		end else begin
			ms_tick <= cyc_q == 32'(CYC_PER_MS - 1);
			cyc_q   <= (cyc_q == 32'(CYC_PER_MS - 1)) ? 32'h0 : cyc_q + 32'h1;
		end
	end

	// strictly greater, so a partial first millisecond never shortens the limit
	assign abort = scl_hold_q && tmo_q != 16'h0 && tmo_ms_q > {1'b0, tmo_q}; // [R11]

	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			scl_hold_q <= 1'b0;
			tmo_ms_q   <= 17'h0;
		end else begin
			scl_hold_q <= stall & ~abort;
			if (!scl_hold_q)
				tmo_ms_q <= 17'h0;
			else if (ms_tick)
				tmo_ms_q <= tmo_ms_q + 17'h1; // [R11]
		end
	end

	assign do_wr = aw_v_q & w_v_q & ~bvalid_q;
	assign ar_hs = ARVALID_I & ~rvalid_q;
	assign rd_stat = ar_hs && ARADDR_I == `I2CTE_A_STAT;
	assign rd_rx   = ar_hs && ARADDR_I == `I2CTE_A_RXD;

	always_comb begin
		wm = 32'h0;
		unique case (aw_q)
			`I2CTE_A_ADDR:   wm = wmerge({25'h0, own_addr_q}, w_q, ws_q);
			`I2CTE_A_CMDLEN: wm = wmerge({24'h0, cmd_len_q}, w_q, ws_q);
			`I2CTE_A_DATLEN: wm = wmerge({24'h0, dat_len_q}, w_q, ws_q);
			`I2CTE_A_HOLD:   wm = wmerge({16'h0, hold_q}, w_q, ws_q);
			`I2CTE_A_TMO:    wm = wmerge({16'h0, tmo_q}, w_q, ws_q);
			`I2CTE_A_MASK:   wm = wmerge({27'h0, mask_q}, w_q, ws_q);
			default:         wm = wmerge(32'h0, w_q, ws_q);
		endcase
	end

	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			own_addr_q <= `I2CTE_RST_ADDR; // [R3]
			cmd_len_q  <= `I2CTE_RST_CMDLEN; // [R5]
			dat_len_q  <= `I2CTE_RST_DATLEN; // [R7]
			hold_q     <= `I2CTE_RST_HOLD; // [R8]
			tmo_q      <= `I2CTE_RST_TMO; // [R11]
			mask_q     <= 5'h0;
			pull_q     <= 1'b0;
		end else if (do_wr) begin
			unique case (aw_q)
				`I2CTE_A_CTRL:   pull_q <= ws_q[0] ? w_q[`I2CTE_CTRL_PULL] : pull_q; // [R12]
				`I2CTE_A_ADDR:   own_addr_q <= wm[6:0];
				`I2CTE_A_CMDLEN: cmd_len_q <= wm[7:0];
				`I2CTE_A_DATLEN: dat_len_q <= wm[7:0];
				`I2CTE_A_HOLD:   hold_q <= wm[15:0];
				`I2CTE_A_TMO:    tmo_q <= wm[15:0];
				`I2CTE_A_MASK:   mask_q <= wm[4:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			attached_q <= 1'b0;
			halted_q   <= 1'b0;
			away_q     <= 1'b0;
			away_ms_q  <= 16'h0;
		end else if (do_wr && aw_q == `I2CTE_A_CTRL && ws_q[0] && w_q[`I2CTE_CTRL_START]) begin
			attached_q <= 1'b1; // [R10]
			halted_q   <= 1'b0;
			away_q     <= 1'b0;
		end else if (do_wr && aw_q == `I2CTE_A_CTRL && ws_q[0] && w_q[`I2CTE_CTRL_STOP]) begin
			attached_q <= 1'b0;
		end else if (xfer_end && writing_q && hold_q != `I2CTE_RST_HOLD) begin // [R8]
			if (hold_q == `I2CTE_HOLD_HALT) begin
				attached_q <= 1'b0; // [R10]
				halted_q   <= 1'b1;
			end else begin
				away_q    <= 1'b1; // [R9]
				away_ms_q <= hold_q;
			end
		end else if (away_q && ms_tick) begin
			// one tick beyond the count, so a partial first millisecond never shortens it
			if (away_ms_q == 16'h0)
				away_q <= 1'b0; // [R9]
			else
				away_ms_q <= away_ms_q - 16'h1;
		end
	end

	// a new event outranks the clear-on-read of the same cycle
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			stat_q        <= 5'h0;
			rd_done_cnt_q <= 8'h00;
			tx_q          <= 8'h00;
			tx_full_q     <= 1'b0;
		end else begin
			stat_q <= (rd_stat ? 5'h0 : stat_q) | {abort, rdn, rrq, raise & ~phase_cmd_q,
				raise & phase_cmd_q}; // [R4] [R7] [R14] [R16]
			if (rdn)
				rd_done_cnt_q <= tx_cnt_q; // [R14]
			if (do_wr && aw_q == `I2CTE_A_TXD && ws_q[0]) begin
				tx_q      <= w_q[7:0];
				tx_full_q <= 1'b1;
			end else if (take) begin
				tx_full_q <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_val = 32'h0;
		unique case (ARADDR_I)
			`I2CTE_A_CTRL:   rd_val[`I2CTE_CTRL_PULL] = pull_q;
			`I2CTE_A_ADDR:   rd_val[6:0] = own_addr_q;
			`I2CTE_A_CMDLEN: rd_val[7:0] = cmd_len_q;
			`I2CTE_A_DATLEN: rd_val[7:0] = dat_len_q;
			`I2CTE_A_HOLD:   rd_val[15:0] = hold_q;
			`I2CTE_A_TMO:    rd_val[15:0] = tmo_q;
			`I2CTE_A_STAT:   rd_val[4:0] = stat_q;
			`I2CTE_A_MASK:   rd_val[4:0] = mask_q;
			`I2CTE_A_RXD:    rd_val[7:0] = pend_any ? buf_q[rd_ptr_q[6:0]] : 8'h00;
			`I2CTE_A_INFO:   rd_val[19:0] = {halted_q, on_bus, dat_pend_q, cmd_pend_q,
				rd_done_cnt_q, ev_cnt_q};
			default:         rd_val = 32'h0;
		endcase
	end

	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			aw_q     <= 8'h00;
			w_q      <= 32'h0;
			ws_q     <= 4'h0;
			aw_v_q   <= 1'b0;
			w_v_q    <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q  <= `I2CTE_RESP_OK;
			rvalid_q <= 1'b0;
			rresp_q  <= `I2CTE_RESP_OK;
			rdata_q  <= 32'h0;
		end else begin
			if (AWVALID_I && !aw_v_q) begin
				aw_q   <= AWADDR_I;
				aw_v_q <= 1'b1;
			end else if (do_wr) begin
				aw_v_q <= 1'b0;
			end
			if (WVALID_I && !w_v_q) begin
				w_q   <= WDATA_I;
				ws_q  <= WSTRB_I;
				w_v_q <= 1'b1;
			end else if (do_wr) begin
				w_v_q <= 1'b0;
			end
			if (do_wr) begin
				bvalid_q <= 1'b1;
				bresp_q  <= reg_hit(aw_q) ? `I2CTE_RESP_OK : `I2CTE_RESP_ERR;
			end else if (BREADY_I) begin
				bvalid_q <= 1'b0;
			end
			if (ar_hs) begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_val;
				rresp_q  <= reg_hit(ARADDR_I) ? `I2CTE_RESP_OK : `I2CTE_RESP_ERR;
			end else if (RREADY_I) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	assign AWREADY_O   = ~aw_v_q;
	assign WREADY_O    = ~w_v_q;
	assign BVALID_O    = bvalid_q;
	assign BRESP_O     = bresp_q;
	assign ARREADY_O   = ~rvalid_q;
	assign RVALID_O    = rvalid_q;
	assign RDATA_O     = rdata_q;
	assign RRESP_O     = rresp_q;
	assign SDA_O       = 1'b0;
	assign SDA_OE_N_O  = ~sda_drv_q;
	assign SCL_O       = 1'b0;
	assign SCL_OE_N_O  = ~scl_hold_q; // [R16]
	assign PULLUP_EN_O = pull_q; // [R12]
	assign IRQ_O       = |(stat_q & mask_q);
endmodule : i2cte_top

// File: testbench/i2cte_monitor.sv
`timescale 1ns/10ps
`include "i2cte_cfg.svh"
module i2cte_monitor (
	input wire logic        CLOCK_I,
	input wire logic        RST_I,
	input wire logic [7:0]  AWADDR_I,
	input wire logic        AWVALID_I,
	input wire logic        AWREADY_O,
	input wire logic [31:0] WDATA_I,
	input wire logic        WVALID_I,
	input wire logic        WREADY_O,
	input wire logic [1:0]  BRESP_O,
	input wire logic        BVALID_O,
	input wire logic        BREADY_I,
	input wire logic        ARVALID_I,
	input wire logic        ARREADY_O,
	input wire logic [31:0] RDATA_O,
	input wire logic        RVALID_O,
	input wire logic        RREADY_I,
	input wire logic        SCL_I,
	input wire logic        SDA_OE_N_O,
	input wire logic        PULLUP_EN_O
);
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (RST_I);
	sequence both_taken;
		AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
	endsequence
	sequence ctrl_write;
		both_taken ##0 AWADDR_I == `I2CTE_A_CTRL;
	endsequence
	bresp_hold_a: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
		else $error("write response dropped early");
	rdata_hold_a: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
		else $error("read data dropped early");
	read_answer_a: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
		else $error("read not answered next cycle");
	read_retire_a: assert property (RVALID_O && RREADY_I |=> !RVALID_O)
		else $error("read data not retired after acceptance");
	write_resp_a: assert property (both_taken |-> ##[1:3] BVALID_O)
		else $error("write response late");
	bresp_code_a: assert property (BVALID_O |-> BRESP_O inside {`I2CTE_RESP_OK, `I2CTE_RESP_ERR})
		else $error("bad write response code");
	w_refuse_a: assert property (WVALID_I && WREADY_O |=> !WREADY_O)
		else $error("second write data taken");
	pull_on_a: assert property (ctrl_write ##0 WDATA_I[2] |-> ##[1:3] PULLUP_EN_O)
		else $error("pull-ups not enabled");
	pull_off_a: assert property (ctrl_write ##0 !WDATA_I[2] |-> ##[1:3] !PULLUP_EN_O)
		else $error("pull-ups not disabled");
	// target data may only move while the clock is low
	sda_quiet_a: assert property ($changed(SDA_OE_N_O) |-> !SCL_I)
		else $error("data line moved with clock high");
endmodule : i2cte_monitor
bind i2cte_top i2cte_monitor i_monitor (.*);

// File: testbench/i2cte_i2c_master.sv
`timescale 1ns/10ps
module i2cte_i2c_master #(
	parameter int QTR = 8
) (
	input  wire logic clk_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_oe_n_o,
	output logic      sda_oe_n_o
);
	int hung = 0;
	initial begin
		scl_oe_n_o = 1'b1;
		sda_oe_n_o = 1'b1;
	end
	task automatic q();
		repeat (QTR) @(posedge clk_i);
	endtask : q
	// bounded, so a target stuck stretching cannot hang the run
	task automatic rise();
		int n;
		n = 0;
		scl_oe_n_o <= 1'b1;
		@(posedge clk_i);
		while (!scl_i && n < 20000) begin
			@(posedge clk_i);
			n++;
		end
		if (!scl_i) hung++;
		q();
	endtask : rise
	task automatic bitx(input logic b, output logic r);
		sda_oe_n_o <= b;
		q();
		rise();
		r = sda_i;
		scl_oe_n_o <= 1'b0;
		q();
	endtask : bitx
	// also serves as a repeated start
	task automatic start();
		sda_oe_n_o <= 1'b1;
		q();
		rise();
		sda_oe_n_o <= 1'b0;
		q();
		scl_oe_n_o <= 1'b0;
		q();
	endtask : start
	task automatic stop();
		sda_oe_n_o <= 1'b0;
		q();
		rise();
		sda_oe_n_o <= 1'b1;
		q();
	endtask : stop
	task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
		output logic nk);
		for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
		bitx(ak, nk);
	endtask : xfer
endmodule : i2cte_i2c_master

// File: testbench/testbench.sv
`timescale 1ns/10ps
`include "i2cte_cfg.svh"
module testbench;
	logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, nk;
	logic        awready, wready, bvalid, arready, rvalid, irq, pull;
	logic        t_scl_n, t_sda_n, m_scl_n, m_sda_n;
	logic [7:0]  awaddr, araddr, rx;
	logic [1:0]  bresp, rresp;
	logic [31:0] wdata, rdata;
	wire         scl = t_scl_n & m_scl_n;
	wire         sda = t_sda_n & m_sda_n;
	int          errors = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          c0;
	logic [7:0]  ra [5] = '{`I2CTE_A_ADDR, `I2CTE_A_CMDLEN, `I2CTE_A_DATLEN, `I2CTE_A_HOLD,
		`I2CTE_A_TMO};
	logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h80, 32'h0, 32'h7530};
	// a 1 ms unit of 1000 cycles keeps hold and timeout runs short
	i2cte_top #(.CYC_PER_MS(1000)) i_dut (
		.CLOCK_I(clk), .RST_I(rst), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
		.AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid),
		.WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
		.ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
		.RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .SCL_I(scl), .SCL_O(),
		.SCL_OE_N_O(t_scl_n), .SDA_I(sda), .SDA_O(), .SDA_OE_N_O(t_sda_n),
		.PULLUP_EN_O(pull), .IRQ_O(irq));
	i2cte_i2c_master #(.QTR(8)) i_master (.clk_i(clk), .scl_i(scl), .sda_i(sda),
		.scl_oe_n_o(m_scl_n), .sda_oe_n_o(m_sda_n));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	task automatic complete_run();
		if (errors == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : complete_run
	task automatic check(input logic [33:0] g, x);
		total_checks++;
		if (g !== x) begin
			errors++;
			$display("ERROR t=%0t got %h exp %h", $time, g, x);
		end
	endtask : check
	task automatic guard(input int n);
		if (n >= 20000) begin
			errors++;
			complete_run();
		end
	endtask : guard
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e = `I2CTE_RESP_OK);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				check(bresp, e);
				bready <= 1'b0;
			end
		end while ((awvalid || wvalid || bready) && n < 20000);
		guard(n);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
		input logic [1:0] r = `I2CTE_RESP_OK);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				check({rresp, rdata & m}, {r, e});
				rready <= 1'b0;
			end
		end while ((arvalid || rready) && n < 20000);
		guard(n);
	endtask : rd
	task automatic wirq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		guard(n);
	endtask : wirq
	task automatic by(input logic [7:0] b, input logic e);
		i_master.xfer(b, 1'b1, rx, nk);
		check(nk, e);
	endtask : by
	// address probe only, then stop
	task automatic ad(input logic e);
		i_master.start();
		by(8'hA0, e);
		i_master.stop();
	endtask : ad
	initial begin
		{rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
		{awaddr, araddr, wdata} = 48'h0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) rd(ra[i], 32'hFFFFFFFF, rv[i]);
		rd(8'h3C, 32'hFFFFFFFF, 32'h0, `I2CTE_RESP_ERR);
		wr(8'h3C, 32'h1, `I2CTE_RESP_ERR);
		wr(`I2CTE_A_ADDR, 32'h50);
		ad(1'b1);
		wr(`I2CTE_A_CTRL, 32'h5);
		check(pull, 1'b1);
		i_master.start();
		by(8'hA2, 1'b1);
		i_master.stop();
		wr(`I2CTE_A_MASK, 32'h1F);
		wr(`I2CTE_A_CMDLEN, 32'h1);
		wr(`I2CTE_A_DATLEN, 32'h2);
		fork
			begin
				i_master.start();
				by(8'hA0, 1'b0);
				by(8'hC5, 1'b0);
				by(8'h3C, 1'b0);
				by(8'hA7, 1'b0);
				i_master.stop();
			end
			begin
				wirq();
				rd(`I2CTE_A_STAT, 32'h1F, 32'h01);
				rd(`I2CTE_A_RXD, 32'hFF, 32'hC5);
				rd(`I2CTE_A_INFO, 32'h10000, 32'h0);
			end
		join
		wirq();
		rd(`I2CTE_A_STAT, 32'h1F, 32'h02);
		rd(`I2CTE_A_INFO, 32'h200FF, 32'h20002);
		rd(`I2CTE_A_RXD, 32'hFF, 32'h3C);
		rd(`I2CTE_A_INFO, 32'h20000, 32'h20000);
		rd(`I2CTE_A_RXD, 32'hFF, 32'hA7);
		rd(`I2CTE_A_INFO, 32'h20000, 32'h0);
		fork
			begin
				i_master.start();
				by(8'hA1, 1'b0);
				i_master.xfer(8'hFF, 1'b1, rx, nk);
				check(rx, 8'h5A);
				i_master.stop();
			end
			begin
				wirq();
				rd(`I2CTE_A_STAT, 32'h1F, 32'h04);
				wr(`I2CTE_A_TXD, 32'h5A);
			end
		join
		wirq();
		rd(`I2CTE_A_STAT, 32'h1F, 32'h08);
		rd(`I2CTE_A_INFO, 32'hFF00, 32'h0100);
		check(irq, 1'b0);
		wr(`I2CTE_A_CMDLEN, 32'h0);
		wr(`I2CTE_A_HOLD, 32'h1);
		i_master.start();
		by(8'hA0, 1'b0);
		by(8'h11, 1'b0);
		by(8'h22, 1'b0);
		i_master.stop();
		rd(`I2CTE_A_STAT, 32'h1F, 32'h02);
		rd(`I2CTE_A_RXD, 32'hFF, 32'h11);
		rd(`I2CTE_A_RXD, 32'hFF, 32'h22);
		ad(1'b1);
		repeat (2000) @(posedge clk);
		ad(1'b0);
		repeat (2000) @(posedge clk);
		wr(`I2CTE_A_HOLD, 32'hFFFF);
		wr(`I2CTE_A_MASK, 32'h0);
		i_master.start();
		by(8'hA0, 1'b0);
		by(8'h33, 1'b0);
		i_master.stop();
		check(irq, 1'b0);
		rd(`I2CTE_A_STAT, 32'h1F, 32'h02);
		rd(`I2CTE_A_RXD, 32'hFF, 32'h33);
		ad(1'b1);
		repeat (1000) @(posedge clk);
		ad(1'b1);
		wr(`I2CTE_A_HOLD, 32'h0);
		wr(`I2CTE_A_CTRL, 32'h1);
		check(pull, 1'b0);
		ad(1'b0);
		wr(`I2CTE_A_MASK, 32'h1F);
		wr(`I2CTE_A_TMO, 32'h1);
		i_master.start();
		by(8'hA1, 1'b0);
		c0 = cyc;
		i_master.xfer(8'hFF, 1'b1, rx, nk);
		check((cyc - c0) > 990, 1'b1);
		i_master.stop();
		rd(`I2CTE_A_STAT, 32'h10, 32'h10);
		check(i_master.hung, 34'h0);
		complete_run();
	end
endmodule : testbench
